// ### design/serial_ctrl.sv
`timescale 1ns/1ps

// Transmit FIFO with valid/ready on both sides and honest full and empty.
module tx_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW-1:0] LAST_SLOT = AW'(D - 1);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s r;
  fifo_s next_r;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != FULL_COUNT);
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap explicitly so that a depth that is not a power of two still works.
  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = (r.wp == LAST_SLOT) ? '0 : r.wp + 1'b1;
    end
    if (pop)
    begin
      next_r.rp = (r.rp == LAST_SLOT) ? '0 : r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    if (flush)
    begin
      next_r.wp = '0;
      next_r.rp = '0;
      next_r.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule : tx_fifo

module serial_ctrl #(
  parameter int FIFO_DEPTH = serial_ctrl_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] controller_mode_select,
  input wire logic underrun_repeat_select,
  input wire logic acknowledge_select,
  input wire logic [3:0] rate_linear_reg,
  input wire logic [3:0] rate_exponent_reg,
  input wire logic data_wr,
  input wire logic [serial_ctrl_pkg::DATA_W-1:0] data_wdata,
  input wire logic data_rd,
  output logic [serial_ctrl_pkg::DATA_W-1:0] data_rdata,
  input wire logic start_segment_set,
  input wire logic stop_segment_set,
  input wire logic transmit_segment_set,
  input wire logic receive_segment_set,
  output logic start_segment_cmd,
  output logic stop_segment_cmd,
  output logic transmit_segment_cmd,
  output logic receive_segment_cmd,
  output logic command_finished_bit,
  output logic tx_finished_bit,
  output logic rx_finished_bit,
  output logic rx_nack_bit,
  output logic tx_idle_bit,
  output logic tx_space_bit,
  output logic rx_valid_bit,
  input wire logic [1:0] tx_dma_buffer_active,
  input wire logic [1:0] rx_dma_buffer_active,
  input wire logic [serial_ctrl_pkg::EV_COUNT-1:0] serial_event_mask_reg,
  input wire logic [serial_ctrl_pkg::EV_COUNT-1:0] event_flag_clear,
  input wire logic top_irq_enable,
  output logic [serial_ctrl_pkg::EV_COUNT-1:0] serial_event_flag_reg,
  output logic tx_underrun_flag,
  output logic tx_idle_event_flag,
  output logic irq,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic slave_select_n,
  output logic spi_miso_out,
  output logic spi_miso_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  import serial_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] mode;
    logic ss_s1, ss_s2;
    logic sck_s1, sck_s2, sck_q;
    logic mosi_s1, mosi_s2;
    logic scl_s1, scl_s2;
    logic sda_s1, sda_s2;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic [7:0] last;
    logic [2:0] bcnt;
    logic have;
    logic pad;
    logic miso_out, miso_oe;
    logic tx_idle, tx_space, rx_valid;
    logic [7:0] rx_data;
    logic [7:0] rdata;
    logic [1:0] txdma_q, rxdma_q;
    logic [EV_COUNT-1:0] flags;
    logic irq;
    i2c_state_e state;
    logic [3:0] ibit;
    logic iphase;
    logic [7:0] ish;
    logic recv;
    logic [DIV_W-1:0] div;
    logic scl_oe, sda_oe;
    logic start_cmd, stop_cmd, send_cmd, recv_cmd;
    logic cmd_fin, tx_fin, rx_fin, rx_nack;
  } ctrl_s;

  ctrl_s r;
  ctrl_s next_r;
  logic tx_in_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_pop;
  logic [EV_COUNT-1:0] ev;
  logic [7:0] fill;
  logic [DIV_W-1:0] half_cycles;
  logic sck_rise, sck_fall, spi_on, i2c_on, tick, got_byte;
  logic [7:0] got_data;

  // The write strobe is refused while the FIFO is full; tx_space_bit shows that.
  tx_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(!r.mode[1]),
    .in_valid(data_wr),
    .in_data(data_wdata),
    .in_ready(tx_in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_pop)
  );

  // Half an SCL period in clk_sys cycles, programmed by the two rate registers.
  assign half_cycles =
    DIV_W'(({1'b0, rate_linear_reg} + 5'h01)) << rate_exponent_reg;

  assign sck_rise = r.sck_s2 && !r.sck_q;
  assign sck_fall = !r.sck_s2 && r.sck_q;
  assign spi_on = (r.mode == MODE_SPI);
  assign i2c_on = (r.mode == MODE_I2C);
  assign tick = (r.div == '0);
  assign fill = underrun_repeat_select ? r.last : BUSY_TOKEN;

  // One combinational pass computes the whole next state of the controller.
  always_comb
  begin
    next_r = r;
    ev = '0;
    tx_pop = 1'b0;
    got_byte = 1'b0;
    got_data = r.rsh;
    // Pin inputs pass two flip-flops; the second stage feeds logic, and SCK also passes a third for edge detection.
    next_r.ss_s1 = slave_select_n;
    next_r.ss_s2 = r.ss_s1;
    next_r.sck_s1 = spi_sck;
    next_r.sck_s2 = r.sck_s1;
    next_r.sck_q = r.sck_s2;
    next_r.mosi_s1 = spi_mosi;
    next_r.mosi_s2 = r.mosi_s1;
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;

    // A mode change between SPI and I2C is taken only via a disabled code.
    if (!r.mode[1] || !controller_mode_select[1])
    begin
      next_r.mode = controller_mode_select;
    end

    // SPI slave serializer, clock mode 0, most significant bit first.
    if (!spi_on || r.ss_s2)
    begin
      next_r.miso_oe = 1'b0;
      next_r.bcnt = '0;
      next_r.rsh = '0;
      // Only an armed pad may be replaced; a loaded data byte must wait for its clocks.
      if (spi_on && tx_valid && (!r.have || r.pad))
      begin
        tx_pop = 1'b1;
        next_r.sh = tx_data;
        next_r.last = tx_data;
        next_r.have = 1'b1;
        next_r.pad = 1'b0;
      end
      else if (spi_on && r.tx_idle && !r.have)
      begin
        next_r.sh = PAD_BYTE;
        next_r.have = 1'b1;
        next_r.pad = 1'b1;
      end
    end
    else
    begin
      next_r.miso_oe = 1'b1;
      if (sck_rise)
      begin
        next_r.rsh = {r.rsh[6:0], r.mosi_s2};
        next_r.bcnt = r.bcnt + 3'h1;
        if (r.bcnt == '0)
        begin
          next_r.tx_idle = 1'b0;
          if (!r.have)
          begin
            next_r.sh = fill;
            next_r.have = 1'b1;
            ev[EV_TX_UNDERRUN] = 1'b1;
          end
        end
        if (r.bcnt == BYTE_LAST_BIT)
        begin
          got_byte = 1'b1;
          got_data = {r.rsh[6:0], r.mosi_s2};
          // No pad here: the next byte follows at once while selected.
          if (tx_valid)
          begin
            tx_pop = 1'b1;
            next_r.sh = tx_data;
            next_r.last = tx_data;
            next_r.pad = 1'b0;
          end
          else
          begin
            next_r.have = 1'b0;
            next_r.tx_idle = 1'b1;
          end
        end
      end
      else if (sck_fall && r.bcnt != '0)
      begin
        next_r.sh = {r.sh[6:0], 1'b0};
      end
      else if (!r.have && r.bcnt == '0 && tx_valid)
      begin
        tx_pop = 1'b1;
        next_r.sh = tx_data;
        next_r.last = tx_data;
        next_r.pad = 1'b0;
        next_r.have = 1'b1;
      end
    end
    next_r.miso_out = next_r.have ? next_r.sh[7] : fill[7];
    next_r.tx_space = tx_in_ready || tx_pop;

    // I2C half-period divider; it restarts whenever a segment is launched.
    next_r.div = tick ? half_cycles - 1'b1 : r.div - 1'b1;
    if (r.state == I2C_IDLE)
    begin
      next_r.div = half_cycles - 1'b1;
    end

    // Command bits are accepted one at a time, only in I2C mode.
    if (i2c_on && !(r.start_cmd || r.stop_cmd || r.send_cmd || r.recv_cmd))
    begin
      next_r.start_cmd = start_segment_set;
      next_r.stop_cmd = stop_segment_set && !start_segment_set;
      next_r.send_cmd = transmit_segment_set && !start_segment_set && !stop_segment_set;
      next_r.recv_cmd = receive_segment_set && !start_segment_set && !stop_segment_set
        && !transmit_segment_set;
    end

    unique case (r.state)
      I2C_IDLE:
      begin
        next_r.ibit = '0;
        next_r.iphase = 1'b0;
        if (r.start_cmd || r.stop_cmd)
        begin
          next_r.state = r.start_cmd ? I2C_START : I2C_STOP;
          next_r.cmd_fin = 1'b0;
        end
        else if (r.send_cmd)
        begin
          next_r.state = I2C_XFER;
          next_r.recv = 1'b0;
          next_r.tx_fin = 1'b0;
          tx_pop = tx_valid;
          next_r.ish = tx_valid ? tx_data : BUSY_TOKEN;
          ev[EV_TX_UNDERRUN] = !tx_valid;
        end
        else if (r.recv_cmd)
        begin
          next_r.state = I2C_XFER;
          next_r.recv = 1'b1;
          next_r.rx_fin = 1'b0;
          next_r.ish = '0;
        end
      end
      I2C_START:
      begin
        // Release SDA and SCL together, pull SDA, pull SCL: also a repeated start.
        if (tick)
        begin
          next_r.ibit = r.ibit + 4'h1;
          next_r.sda_oe = (r.ibit >= 4'h2);
          next_r.scl_oe = (r.ibit == START_LAST_STEP);
          if (r.ibit == START_LAST_STEP)
          begin
            next_r.state = I2C_IDLE;
            next_r.start_cmd = 1'b0;
            next_r.cmd_fin = 1'b1;
          end
        end
      end
      I2C_STOP:
      begin
        // Pull SDA with SCL low, release SCL, then release SDA.
        if (tick)
        begin
          next_r.ibit = r.ibit + 4'h1;
          next_r.sda_oe = (r.ibit != STOP_LAST_STEP);
          next_r.scl_oe = (r.ibit == '0);
          if (r.ibit == STOP_LAST_STEP)
          begin
            next_r.state = I2C_IDLE;
            next_r.stop_cmd = 1'b0;
            next_r.cmd_fin = 1'b1;
          end
        end
      end
      I2C_XFER:
      begin
        // Two ticks per bit: SCL low with new data, then SCL released.
        if (tick && r.iphase)
        begin
          next_r.scl_oe = 1'b0;
          next_r.iphase = 1'b0;
        end
        else if (tick)
        begin
          next_r.scl_oe = 1'b1;
          if (r.ibit != '0 && r.ibit <= I2C_ACK_BIT)
          begin
            next_r.ish = {r.ish[6:0], r.scl_s2 ? r.sda_s2 : 1'b1};
          end
          else if (r.ibit == I2C_XFER_END && !r.recv)
          begin
            next_r.rx_nack = r.sda_s2;
            ev[EV_NACK] = r.sda_s2;
          end
          if (r.ibit == I2C_XFER_END)
          begin
            next_r.sda_oe = 1'b0;
            next_r.state = I2C_IDLE;
            next_r.send_cmd = 1'b0;
            next_r.recv_cmd = 1'b0;
            next_r.tx_fin = !r.recv;
            next_r.rx_fin = r.recv;
            got_byte = r.recv;
            got_data = r.ish;
          end
          else
          begin
            next_r.ibit = r.ibit + 4'h1;
            next_r.iphase = 1'b1;
            if (r.ibit == I2C_ACK_BIT)
            begin
              next_r.sda_oe = r.recv && acknowledge_select;
            end
            else
            begin
              next_r.sda_oe = !r.recv && !next_r.ish[7];
            end
          end
        end
      end
    endcase
    // Judged on the next mode so that no segment outlives the I2C mode by a cycle.
    if (next_r.mode != MODE_I2C)
    begin
      next_r.state = I2C_IDLE;
      next_r.scl_oe = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.start_cmd = 1'b0;
      next_r.stop_cmd = 1'b0;
      next_r.send_cmd = 1'b0;
      next_r.recv_cmd = 1'b0;
    end

    // Receive holding register: a read pops, and a byte on arrival is kept or lost.
    if (data_rd && r.rx_valid)
    begin
      next_r.rdata = r.rx_data;
      next_r.rx_valid = 1'b0;
    end
    if (got_byte)
    begin
      if (next_r.rx_valid)
      begin
        ev[EV_RX_OVERRUN] = 1'b1;
      end
      else
      begin
        next_r.rx_data = got_data;
        next_r.rx_valid = 1'b1;
      end
    end

    // Event sources; a set in the same cycle as a clear wins.
    next_r.txdma_q = tx_dma_buffer_active;
    next_r.rxdma_q = rx_dma_buffer_active;
    ev[EV_TX_IDLE] = next_r.tx_idle && !r.tx_idle;
    ev[EV_TX_SPACE] = next_r.tx_space && !r.tx_space;
    ev[EV_RX_VALID] = next_r.rx_valid && !r.rx_valid;
    ev[EV_TX_DMA_DONE] = |(r.txdma_q & ~tx_dma_buffer_active);
    ev[EV_RX_DMA_DONE] = |(r.rxdma_q & ~rx_dma_buffer_active);
    ev[EV_CMD_FIN] = next_r.cmd_fin && !r.cmd_fin;
    ev[EV_TX_FIN] = next_r.tx_fin && !r.tx_fin;
    ev[EV_RX_FIN] = next_r.rx_fin && !r.rx_fin;
    next_r.flags = (r.flags & ~event_flag_clear) | ev;
    next_r.irq = top_irq_enable && |(next_r.flags & serial_event_mask_reg);
  end

  // Reset leaves the controller disabled, idle and with every flag clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.tx_idle <= 1'b1;
      r.tx_space <= 1'b1;
      r.ss_s1 <= 1'b1;
      r.ss_s2 <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign data_rdata = r.rdata;
  assign start_segment_cmd = r.start_cmd;
  assign stop_segment_cmd = r.stop_cmd;
  assign transmit_segment_cmd = r.send_cmd;
  assign receive_segment_cmd = r.recv_cmd;
  assign command_finished_bit = r.cmd_fin;
  assign tx_finished_bit = r.tx_fin;
  assign rx_finished_bit = r.rx_fin;
  assign rx_nack_bit = r.rx_nack;
  assign tx_idle_bit = r.tx_idle;
  assign tx_space_bit = r.tx_space;
  assign rx_valid_bit = r.rx_valid;
  assign serial_event_flag_reg = r.flags;
  assign tx_underrun_flag = r.flags[EV_TX_UNDERRUN];
  assign tx_idle_event_flag = r.flags[EV_TX_IDLE];
  assign irq = r.irq;
  assign spi_miso_out = r.miso_out;
  assign spi_miso_oe = r.miso_oe;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_underrun_edge;
    spi_on && !r.ss_s2 && sck_rise && r.bcnt == '0 && !r.have;
  endsequence

  sequence s_mode_hop;
    r.mode[1] ##1 (r.mode[1] && r.mode != $past(r.mode));
  endsequence

  a_underrun_flag: assert property (s_underrun_edge |=> tx_underrun_flag)
    else $error("underrun edge did not set the underrun flag");
  a_fill_byte: assert property (s_underrun_edge |=>
    r.sh == ($past(underrun_repeat_select) ? $past(r.last) : BUSY_TOKEN))
    else $error("underrun byte is neither the last byte nor the busy token");
  a_idle_clear: assert property (spi_on && !r.ss_s2 && sck_rise && r.bcnt == '0
    |=> !tx_idle_bit ##1 !tx_idle_bit)
    else $error("idle bit did not clear on the first clock of a byte");
  a_space_full: assert property (!tx_in_ready && !tx_pop |=> !tx_space_bit)
    else $error("space bit set while the fifo is full");
  a_pad_arm: assert property (spi_on && r.ss_s2 && !tx_valid && r.tx_idle && !r.have
    |=> r.have && r.sh == PAD_BYTE)
    else $error("pad byte not armed while deselected and idle");
  a_direct_load: assert property (spi_on && r.ss_s2 && tx_valid && !r.have
    |-> tx_pop ##1 r.have)
    else $error("byte written while deselected did not load the serializer");
  a_miso_float: assert property (r.ss_s2 |=> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_irq_gate: assert property (irq |-> $past(top_irq_enable)
    && |(serial_event_flag_reg & $past(serial_event_mask_reg)))
    else $error("interrupt raised without both enables");
  a_mode_detour: assert property (not s_mode_hop)
    else $error("mode changed between spi and i2c without disabling");
  a_i2c_only: assert property (r.state != I2C_IDLE |-> r.mode == MODE_I2C)
    else $error("i2c segment running outside i2c mode");
  a_cmd_done: assert property ($fell(start_segment_cmd) && r.mode == MODE_I2C
    |-> command_finished_bit)
    else $error("start command cleared without command finished");

endmodule : serial_ctrl

// ### design/serial_ctrl_pkg.sv
package serial_ctrl_pkg;

  // System clock rate; the I2C divider counts these cycles directly.
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int SYS_CLK_NS = 1_000_000_000 / SYS_CLK_HZ;

  // Controller mode select codes.
  localparam logic [1:0] MODE_OFF0 = 2'h0;
  localparam logic [1:0] MODE_OFF1 = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h2;
  localparam logic [1:0] MODE_I2C = 2'h3;

  // Byte values put on the wire by the transmit serializer.
  localparam logic [7:0] PAD_BYTE = 8'hFF;
  localparam logic [7:0] BUSY_TOKEN = 8'hFF;

  // Data path sizes.
  localparam int DATA_W = 8;
  localparam int TX_FIFO_DEPTH = 16;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam logic [3:0] I2C_XFER_END = 4'h9;
  localparam logic [3:0] START_LAST_STEP = 4'h3;
  localparam logic [3:0] STOP_LAST_STEP = 4'h2;
  localparam int DIV_W = 20;

  // Event flag positions in the serial event flag register.
  localparam int EV_TX_IDLE = 0;
  localparam int EV_TX_SPACE = 1;
  localparam int EV_RX_VALID = 2;
  localparam int EV_RX_OVERRUN = 3;
  localparam int EV_TX_UNDERRUN = 4;
  localparam int EV_TX_DMA_DONE = 5;
  localparam int EV_RX_DMA_DONE = 6;
  localparam int EV_CMD_FIN = 7;
  localparam int EV_TX_FIN = 8;
  localparam int EV_RX_FIN = 9;
  localparam int EV_NACK = 10;
  localparam int EV_COUNT = 11;

  typedef enum logic [1:0] {I2C_IDLE, I2C_START, I2C_STOP, I2C_XFER} i2c_state_e;

endpackage : serial_ctrl_pkg

// ### verif/serial_ctrl_spi_slave_i2c_master_tb.sv
`timescale 1ns/1ps

module serial_ctrl_spi_slave_i2c_master_tb;
  import serial_ctrl_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, rpt = 1'b0, wr = 1'b0, st = 1'b0, sp = 1'b0, tx = 1'b0;
  logic top = 1'b0, rv = 1'b0, rd = 1'b0, ack = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] wd = 8'h00, rdata, q;
  logic [3:0] lin = 4'h1, ex = 4'h1, dma = 4'h0;
  logic [10:0] mask = 11'h000, clr = 11'h000, flags;
  logic scmd, pcmd, tcmd, rcmd, cfin, tfin, rfin, nack, idle, space, rxv, und, iev, irq;
  logic miso, moe, sclo, scloe, sdao, sdaoe;
  wire sck, mosi, ssn;
  wire scl = ~scloe; // Open drain with an external pull-up.
  wire sda = ~sdaoe;
  int mismatches = 0, checks = 0;

  serial_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn), .controller_mode_select(mode),
    .underrun_repeat_select(rpt), .acknowledge_select(ack), .rate_linear_reg(lin),
    .rate_exponent_reg(ex), .data_wr(wr), .data_wdata(wd), .data_rd(rd),
    .data_rdata(rdata), .start_segment_set(st), .stop_segment_set(sp),
    .transmit_segment_set(tx), .receive_segment_set(rv), .start_segment_cmd(scmd),
    .stop_segment_cmd(pcmd), .transmit_segment_cmd(tcmd), .receive_segment_cmd(rcmd),
    .command_finished_bit(cfin), .tx_finished_bit(tfin), .rx_finished_bit(rfin),
    .rx_nack_bit(nack), .tx_idle_bit(idle), .tx_space_bit(space), .rx_valid_bit(rxv),
    .tx_dma_buffer_active(dma[1:0]), .rx_dma_buffer_active(dma[3:2]),
    .serial_event_mask_reg(mask), .event_flag_clear(clr), .top_irq_enable(top),
    .serial_event_flag_reg(flags), .tx_underrun_flag(und), .tx_idle_event_flag(iev),
    .irq(irq), .spi_sck(sck), .spi_mosi(mosi), .slave_select_n(ssn), .spi_miso_out(miso),
    .spi_miso_oe(moe), .scl_in(scl), .sda_in(sda), .scl_out(sclo), .scl_oe(scloe),
    .sda_out(sdao), .sda_oe(sdaoe));
  spi_master_model u_master (.clk(clk_sys), .sck(sck), .mosi(mosi), .ssn(ssn), .miso(miso));

  // A 25 MHz system clock.
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic wr_byte(input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    wd <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_byte

  // Queue a byte before the master selects, then run the FIFO dry.
  task automatic t_spi;
    mode <= MODE_SPI;
    wr_byte(8'h5A);
    repeat (8) @(posedge clk_sys);
    chk("wr_quiet", 11'h003, {|flags, idle, space});
    u_master.sel(1'b1);
    chk("miso_oe", 1, moe);
    u_master.xfer(8'h11, q);
    chk("first", 8'h5A, q);
    chk("idle", 1, idle);
    rpt <= 1'b1;
    clr <= 11'h7FF;
    @(posedge clk_sys);
    clr <= 11'h000;
    u_master.xfer(8'h22, q);
    chk("repeat", 8'h5A, q);
    chk("underrun", 1, und);
    chk("idle_ev", 1, iev);
    chk("overrun", 1, flags[EV_RX_OVERRUN]);
    rpt <= 1'b0;
    u_master.xfer(8'h33, q);
    chk("busy", BUSY_TOKEN, q);
    u_master.sel(1'b0);
    chk("miso_oe", 0, moe);
    @(posedge clk_sys);
    clr <= 11'h7FF;
    @(posedge clk_sys);
    clr <= 11'h000;
    // Selected with nothing queued: the pad leads the later byte.
    u_master.sel(1'b1);
    wr_byte(8'hC3);
    u_master.xfer(8'h44, q);
    chk("pad", PAD_BYTE, q);
    u_master.xfer(8'h55, q);
    chk("after_pad", 8'hC3, q);
    u_master.sel(1'b0);
  endtask : t_spi

  // Fill until the space bit drops, then free one slot.
  task automatic t_full;
    for (int i = 0; i < 20 && space === 1'b1; i++)
      wr_byte(i[7:0]);
    @(negedge clk_sys);
    chk("space_full", 0, space);
    u_master.sel(1'b1);
    u_master.xfer(8'h66, q);
    chk("space_free", 1, space);
    chk("space_ev", 1, flags[EV_TX_SPACE]);
    u_master.sel(1'b0);
    mode <= MODE_OFF0;
    repeat (4) @(posedge clk_sys);
  endtask : t_full

  // DMA completion events pass to irq only with both enables.
  task automatic t_events;
    @(posedge clk_sys);
    clr <= 11'h7FF;
    dma <= 4'hF;
    mask <= 11'h060;
    @(posedge clk_sys);
    clr <= 11'h000;
    @(posedge clk_sys);
    dma <= 4'h0;
    repeat (3) @(posedge clk_sys);
    chk("dma_ev", 11'h060, flags & 11'h060);
    chk("irq_top_off", 0, irq);
    top <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("irq_on", 1, irq);
    mask <= 11'h000;
    repeat (3) @(posedge clk_sys);
    chk("irq_masked", 0, irq);
  endtask : t_events

  // Pulse one segment request, wait for it to end and catch SDA at every SCL rise.
  task automatic seg(input logic [3:0] req, output logic [8:0] bits, output int gap);
    logic prev;
    int cyc;
    prev = scl;
    cyc = 0;
    bits = '0;
    gap = 0;
    @(posedge clk_sys);
    {st, sp, tx, rv} <= req;
    @(posedge clk_sys);
    {st, sp, tx, rv} <= 4'h0;
    for (int i = 0; i < 2000 && ({scmd, pcmd, tcmd, rcmd} !== 4'h0 || i < 2); i++)
    begin
      @(negedge clk_sys);
      cyc++;
      if (scl && !prev)
      begin
        bits = {bits[7:0], sda};
        gap = cyc;
        cyc = 0;
      end
      prev = scl;
    end
    // A segment that never ends is a mismatch and closes the run at once.
    if ({scmd, pcmd, tcmd, rcmd} !== 4'h0)
    begin
      chk("seg_timeout", 0, {scmd, pcmd, tcmd, rcmd});
      test_done();
    end
  endtask : seg

  // Start, address byte, one byte received with ACK, then stop; no slave answers.
  task automatic t_i2c;
    logic [8:0] bits;
    int gap;
    mode <= MODE_I2C;
    lin <= 4'h3;
    ex <= 4'h0;
    ack <= 1'b1;
    rd <= 1'b1;
    wr_byte({7'h52, 1'b1});
    rd <= 1'b0;
    chk("rdata", 8'h11, rdata);
    seg(4'h8, bits, gap);
    chk("start_done", 11'h001, {scmd, cfin});
    seg(4'h2, bits, gap);
    chk("addr_byte", {7'h52, 1'b1, 1'b1}, bits);
    chk("tx_fin_nack", 11'h003, {tfin, nack});
    // One SCL period is two half periods of (3 + 1) << 0 system clocks.
    chk("scl_period", 8, gap);
    seg(4'h1, bits, gap);
    chk("ack_sent", 0, bits[0]);
    chk("rx_fin", 11'h003, {rfin, rxv});
    seg(4'h4, bits, gap);
    chk("stop_done", 11'h001, {pcmd, cfin});
    chk("pins_free", 0, {sclo, sdao, scloe, sdaoe});
  endtask : t_i2c

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("reset", 11'h003, {irq, flags[EV_TX_UNDERRUN], moe, scloe, sdaoe, idle, space});
    chk("flags", 0, flags);
    t_spi();
    t_full();
    t_events();
    t_i2c();
    test_done();
  end
endmodule : serial_ctrl_spi_slave_i2c_master_tb

// ### verif/spi_master_model.sv
`timescale 1ns/1ps

// Behavioural SPI master, mode 0, MSB first; its clock stands still between frames.
module spi_master_model (
  input wire logic clk,
  output logic sck,
  output logic mosi,
  output logic ssn,
  input wire logic miso
);
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    ssn = 1'b1;
  end

  // Pins move on falling clock edges only, so the slave never samples them mid-change.
  task automatic sel(input logic on);
    @(negedge clk);
    ssn = ~on;
    repeat (10) @(negedge clk);
  endtask : sel

  // One byte each way; four system clocks per phase suit the slave's synchronisers.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = d[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      q = {q[6:0], miso};
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    mosi = ~mosi; // A released line must not keep showing the last bit.
    repeat (10) @(negedge clk);
  endtask : xfer
endmodule : spi_master_model
